// >>> inc/gio_pkg.sv
// Purpose: constants and types shared by the general I/O port logic
// Assumes: AXI4-Lite register access, 32-bit data, 8-bit byte addresses
// Notes:   register indices are kept as printed; byte address is four times the index
package gio_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] IDX_PA_DATA = 8'h02;
    localparam logic [ADDR_W-1:0] IDX_PA_DIR = 8'h03;
    localparam logic [ADDR_W-1:0] IDX_PB_DATA = 8'h04;
    localparam logic [ADDR_W-1:0] IDX_PB_DIR = 8'h05;
    localparam logic [ADDR_W-1:0] IDX_DRIVE_SEL = 8'h06;
    localparam logic [ADDR_W-1:0] ADDR_PA_DATA = 8'(IDX_PA_DATA * 4);
    localparam logic [ADDR_W-1:0] ADDR_PA_DIR = 8'(IDX_PA_DIR * 4);
    localparam logic [ADDR_W-1:0] ADDR_PB_DATA = 8'(IDX_PB_DATA * 4);
    localparam logic [ADDR_W-1:0] ADDR_PB_DIR = 8'(IDX_PB_DIR * 4);
    localparam logic [ADDR_W-1:0] ADDR_DRIVE_SEL = 8'(IDX_DRIVE_SEL * 4);

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [7:0] PB_PIN_MASK = 8'h0f;
    localparam int PB_PINS = 4;
    localparam int PULSE_CHANNELS = 6;
    localparam int BUZZER_PIN = 5;
    localparam int PIN4_DRIVE_BIT = 1;
    localparam int PIN5_DRIVE_BIT = 2;
    localparam int IFR_PIN = 3;
    localparam logic [1:0] DRIVE_RESET = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] data;
    } gio_port_regs_t;

    typedef struct packed {
        logic [1:0] resp;
        logic [31:0] data;
    } gio_rd_word_t;

endpackage : gio_pkg

// >>> verilog/gio_port.sv
// Purpose: general I/O ports A and B with alternate functions, AXI4-Lite registers
// Assumes: pins and peripheral signals synchronous to clk_in (50 MHz)
// Notes:   pin outputs are registered, one cycle behind their cause
`timescale 1ns/1ps
`default_nettype none

// Contract
// - direction bit 1 output, 0 input; read/write
// - port writes update stored data only when write strobe bit 0 is set
// - read gives data if output, pin if input
// - missing pin positions read zero
// - reset clears all direction and data bits
// - input mode: driver off, read from pin
// - output mode: drive and read stored bit
// - peripheral alternate output forces pin output
// - port A pins 0-5 carry pulse outputs
// - buzzer beats pulse channel 5 on pin 5
// - drive bit 2 selects pin 5 high drive
// - drive bit 1 selects pin 4 high drive
// - drive bits 7..3 read zero, ignore writes
// - converter channel code connects port B pin
// - channel 3 selection disables infrared input
module gio_port
    import gio_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // axi4-lite write
    input wire logic [ADDR_W-1:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    // port pins
    input wire logic [7:0] pa_pin_in,
    output logic [7:0] pa_pin_out,
    output logic [7:0] pa_pin_oe_out,
    input wire logic [PB_PINS-1:0] pb_pin_in,
    output logic [PB_PINS-1:0] pb_pin_out,
    output logic [PB_PINS-1:0] pb_pin_oe_out,
    // peripherals
    input wire logic [PULSE_CHANNELS-1:0] pulse_channel_output_enable_in,
    input wire logic [PULSE_CHANNELS-1:0] pulse_channel_in,
    input wire logic buzzer_enable_in,
    input wire logic buzzer_output_in,
    input wire logic converter_power_on_in,
    input wire logic [1:0] analog_channel_select_in,
    output logic pin4_high_drive_out,
    output logic pin5_high_drive_out,
    output logic [PB_PINS-1:0] analog_switch_en_out,
    output logic infrared_controller_out,
    output logic [7:0] pa_level_out,
    output logic [PB_PINS-1:0] pb_level_out
);

    // ------------------------------------------------------------
    // input synchroniser
    // ------------------------------------------------------------
    logic [7:0] pa_meta_ff, pa_sync_ff;
    logic [PB_PINS-1:0] pb_meta_ff, pb_sync_ff;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pa_meta_ff <= 8'h00;
            pa_sync_ff <= 8'h00;
            pb_meta_ff <= 4'h0;
            pb_sync_ff <= 4'h0;
        end else begin
            pa_meta_ff <= pa_pin_in;
            pa_sync_ff <= pa_meta_ff;
            pb_meta_ff <= pb_pin_in;
            pb_sync_ff <= pb_meta_ff;
        end
    end

    assign pa_level_out = pa_sync_ff;
    assign pb_level_out = pb_sync_ff;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    gio_port_regs_t pa_ff, nxt_pa, pb_ff, nxt_pb;
    logic [1:0] drive_ff, nxt_drive;
    logic aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
    logic [ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
    logic [7:0] w_byte_ff, nxt_w_byte;
    logic w_lane_ff, nxt_w_lane;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic do_wr;

    assign do_wr = aw_held_ff && w_held_ff && !bvalid_ff;
    assign awready_out = !aw_held_ff;
    assign wready_out = !w_held_ff;
    assign bvalid_out = bvalid_ff;
    assign bresp_out = bresp_ff;

    always_comb begin
        nxt_pa = pa_ff;
        nxt_pb = pb_ff;
        nxt_drive = drive_ff;
        nxt_aw_held = aw_held_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_held = w_held_ff;
        nxt_w_byte = w_byte_ff;
        nxt_w_lane = w_lane_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        // address and data are taken independently, in either order
        if (awvalid_in && !aw_held_ff) begin
            nxt_aw_held = 1'b1;
            nxt_aw_addr = awaddr_in;
        end
        if (wvalid_in && !w_held_ff) begin
            nxt_w_held = 1'b1;
            nxt_w_byte = wdata_in[7:0];
            nxt_w_lane = wstrb_in[0];
        end
        if (bvalid_ff && bready_in) begin
            nxt_bvalid = 1'b0;
        end
        if (do_wr) begin
            nxt_aw_held = 1'b0;
            nxt_w_held = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = RESP_OKAY;
            case (aw_addr_ff)
                ADDR_PA_DATA: if (w_lane_ff) nxt_pa.data = w_byte_ff;
                ADDR_PA_DIR: if (w_lane_ff) nxt_pa.dir = w_byte_ff;
                ADDR_PB_DATA: if (w_lane_ff) nxt_pb.data = w_byte_ff & PB_PIN_MASK;
                ADDR_PB_DIR: if (w_lane_ff) nxt_pb.dir = w_byte_ff & PB_PIN_MASK;
                ADDR_DRIVE_SEL: begin
                    // only the two drive bits are stored
                    if (w_lane_ff) nxt_drive = w_byte_ff[PIN5_DRIVE_BIT:PIN4_DRIVE_BIT];
                end
                default: nxt_bresp = RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pa_ff <= '{dir: PORT_RESET, data: PORT_RESET};
            pb_ff <= '{dir: PORT_RESET, data: PORT_RESET};
            drive_ff <= DRIVE_RESET;
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_held_ff <= 1'b0;
            w_byte_ff <= 8'h00;
            w_lane_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else begin
            pa_ff <= nxt_pa;
            pb_ff <= nxt_pb;
            drive_ff <= nxt_drive;
            aw_held_ff <= nxt_aw_held;
            aw_addr_ff <= nxt_aw_addr;
            w_held_ff <= nxt_w_held;
            w_byte_ff <= nxt_w_byte;
            w_lane_ff <= nxt_w_lane;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    logic [7:0] pa_read, pb_read;
    gio_rd_word_t rd_ff, nxt_rd;
    logic rvalid_ff, nxt_rvalid;

    assign pa_read = (pa_ff.dir & pa_ff.data) | (~pa_ff.dir & pa_sync_ff);
    assign pb_read = ((pb_ff.dir & pb_ff.data) | (~pb_ff.dir & {4'h0, pb_sync_ff}))
        & PB_PIN_MASK;
    assign arready_out = !rvalid_ff;
    assign rvalid_out = rvalid_ff;
    assign rdata_out = rd_ff.data;
    assign rresp_out = rd_ff.resp;

    always_comb begin
        nxt_rd = rd_ff;
        nxt_rvalid = rvalid_ff;
        if (rvalid_ff && rready_in) begin
            nxt_rvalid = 1'b0;
        end
        if (arvalid_in && !rvalid_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rd.resp = RESP_OKAY;
            nxt_rd.data = 32'h0000_0000;
            case (araddr_in)
                ADDR_PA_DATA: nxt_rd.data[7:0] = pa_read;
                ADDR_PA_DIR: nxt_rd.data[7:0] = pa_ff.dir;
                ADDR_PB_DATA: nxt_rd.data[7:0] = pb_read;
                ADDR_PB_DIR: nxt_rd.data[7:0] = pb_ff.dir;
                ADDR_DRIVE_SEL: nxt_rd.data[PIN5_DRIVE_BIT:PIN4_DRIVE_BIT] = drive_ff;
                default: nxt_rd.resp = RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_ff <= '{resp: RESP_OKAY, data: 32'h0000_0000};
            rvalid_ff <= 1'b0;
        end else begin
            rd_ff <= nxt_rd;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // ------------------------------------------------------------
    // pin drivers and alternate functions
    // ------------------------------------------------------------
    logic [7:0] pa_alt_en, pa_alt_val;
    logic [7:0] pa_out_ff, nxt_pa_out, pa_oe_ff, nxt_pa_oe;
    logic [PB_PINS-1:0] pb_out_ff, nxt_pb_out, pb_oe_ff, nxt_pb_oe;
    logic [1:0] hd_ff, nxt_hd;
    logic [PB_PINS-1:0] asw_ff, nxt_asw;
    logic ifr_ff, nxt_ifr;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pa_alt
            if (gi == BUZZER_PIN) begin : g_buz
                // buzzer has priority over the pulse channel here
                assign pa_alt_en[gi] = pulse_channel_output_enable_in[gi] || buzzer_enable_in;
                assign pa_alt_val[gi] = buzzer_enable_in ? buzzer_output_in
                    : pulse_channel_in[gi];
            end else if (gi < PULSE_CHANNELS) begin : g_pwm
                assign pa_alt_en[gi] = pulse_channel_output_enable_in[gi];
                assign pa_alt_val[gi] = pulse_channel_in[gi];
            end else begin : g_none
                assign pa_alt_en[gi] = 1'b0;
                assign pa_alt_val[gi] = 1'b0;
            end
        end
    endgenerate

    always_comb begin
        nxt_pa_oe = pa_ff.dir | pa_alt_en;
        nxt_pa_out = (pa_alt_en & pa_alt_val) | (~pa_alt_en & pa_ff.data);
        nxt_pb_oe = pb_ff.dir[PB_PINS-1:0];
        nxt_pb_out = pb_ff.data[PB_PINS-1:0];
        // high drive means nothing while the pin is not driven
        nxt_hd[1] = drive_ff[1] && nxt_pa_oe[5];
        nxt_hd[0] = drive_ff[0] && nxt_pa_oe[4];
        nxt_asw = 4'h0;
        if (converter_power_on_in) begin
            nxt_asw[analog_channel_select_in] = 1'b1;
        end
        nxt_ifr = pb_sync_ff[IFR_PIN] && !nxt_asw[IFR_PIN];
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pa_out_ff <= 8'h00;
            pa_oe_ff <= 8'h00;
            pb_out_ff <= 4'h0;
            pb_oe_ff <= 4'h0;
            hd_ff <= 2'h0;
            asw_ff <= 4'h0;
            ifr_ff <= 1'b0;
        end else begin
            pa_out_ff <= nxt_pa_out;
            pa_oe_ff <= nxt_pa_oe;
            pb_out_ff <= nxt_pb_out;
            pb_oe_ff <= nxt_pb_oe;
            hd_ff <= nxt_hd;
            asw_ff <= nxt_asw;
            ifr_ff <= nxt_ifr;
        end
    end

    assign pa_pin_out = pa_out_ff;
    assign pa_pin_oe_out = pa_oe_ff;
    assign pb_pin_out = pb_out_ff;
    assign pb_pin_oe_out = pb_oe_ff;
    assign pin5_high_drive_out = hd_ff[1];
    assign pin4_high_drive_out = hd_ff[0];
    assign analog_switch_en_out = asw_ff;
    assign infrared_controller_out = ifr_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_ar_taken;
        arvalid_in && arready_out;
    endsequence
    sequence s_r_answer;
        rvalid_out ##0 !arready_out;
    endsequence

    a_read_answer: assert property (s_ar_taken |=> s_r_answer)
        else $error("read not answered next cycle");
    a_write_answer: assert property (do_wr |=> bvalid_out && awready_out && wready_out)
        else $error("write not answered next cycle");
    a_reset_clear: assert property ($fell(rst_in) |-> pa_ff == '0 && pb_ff == '0)
        else $error("port state not cleared by reset");
    a_data_write: assert property (do_wr && aw_addr_ff == ADDR_PA_DATA && w_lane_ff
        |=> pa_ff.data == $past(w_byte_ff))
        else $error("port data write lost");
    a_input_undriven: assert property (!pa_ff.dir[6] |=> !pa_pin_oe_out[6])
        else $error("input pin driven");
    a_output_drives: assert property (pa_ff.dir[7] |=> pa_pin_oe_out[7]
        && pa_pin_out[7] == $past(pa_ff.data[7]))
        else $error("output pin not driving stored bit");
    a_alt_forces_out: assert property (pulse_channel_output_enable_in[0]
        |=> pa_pin_oe_out[0] && pa_pin_out[0] == $past(pulse_channel_in[0]))
        else $error("alternate output not driven");
    a_buzzer_wins: assert property (buzzer_enable_in && pulse_channel_output_enable_in[5]
        |=> pa_pin_out[5] == $past(buzzer_output_in))
        else $error("buzzer lost priority on pin 5");
    a_drive_needs_oe: assert property ((pin5_high_drive_out |-> pa_pin_oe_out[5])
        and (pin4_high_drive_out |-> pa_pin_oe_out[4]))
        else $error("high drive on undriven pin");
    a_analog_select: assert property (converter_power_on_in && analog_channel_select_in == 2'h2
        |=> analog_switch_en_out == 4'h4)
        else $error("wrong analog switch");
    a_ifr_cut: assert property (analog_switch_en_out[IFR_PIN] |-> !infrared_controller_out)
        else $error("infrared input not cut");
    a_sync_depth: assert property ($past(!rst_in) && $past(!rst_in, 2)
        |-> pb_level_out == $past(pb_pin_in, 2))
        else $error("pin level not two cycles behind");
    a_read_zero_hi: assert property (rvalid_out |-> rdata_out[31:8] == 24'h000000)
        else $error("upper read bits not zero");

endmodule : gio_port

`default_nettype wire

// >>> tb/gio_pin_model.sv
// Purpose: board side of the general I/O pins
// Assumes: weak pull-up on port A pins, port B pins always driven by the board
// Notes:   a board driver only acts where the port itself is not driving
`timescale 1ns/1ps
`default_nettype none

module gio_pin_model (
    // port side
    input wire logic [7:0] pa_pin_out,
    input wire logic [7:0] pa_pin_oe_out,
    input wire logic [3:0] pb_pin_out,
    input wire logic [3:0] pb_pin_oe_out,
    // board drivers
    input wire logic [7:0] pa_ext_in,
    input wire logic [7:0] pa_ext_en_in,
    input wire logic [3:0] pb_ext_in,
    // resolved pin levels
    output logic [7:0] pa_level_out,
    output logic [3:0] pb_level_out
);
    // --------------------------------------------------------
    // wire resolution
    // --------------------------------------------------------
    // undriven port A pin floats to the pull-up, never to a stale value
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pa_level_out[i] = pa_pin_oe_out[i] ? pa_pin_out[i] :
                (pa_ext_en_in[i] ? pa_ext_in[i] : 1'b1);
        end
        for (int i = 0; i < 4; i++) begin
            pb_level_out[i] = pb_pin_oe_out[i] ? pb_pin_out[i] : pb_ext_in[i];
        end
    end
endmodule : gio_pin_model

`default_nettype wire

// >>> tb/testbench.sv
// Purpose: self-checking bench for the general I/O port block
// Assumes: AXI4-Lite master tasks, board pins from gio_pin_model
// Notes:   pin effects are checked after a few settling edges
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import gio_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] awaddr_in = 8'h00, araddr_in = 8'h00;
    logic awvalid_in = 1'b0, wvalid_in = 1'b0, arvalid_in = 1'b0;
    logic bready_in = 1'b1, rready_in = 1'b1;
    logic [31:0] wdata_in = 32'h0;
    logic [3:0] wstrb_in = 4'h1;
    logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
    logic [1:0] bresp_out, rresp_out, analog_channel_select_in = 2'h0;
    logic [31:0] rdata_out;
    logic [7:0] pa_pin_in, pa_pin_out, pa_pin_oe_out, pa_level_out;
    logic [7:0] pa_ext = 8'h00, pa_ext_en = 8'h00;
    logic [3:0] pb_pin_in, pb_pin_out, pb_pin_oe_out, pb_level_out;
    logic [3:0] pb_ext = 4'h0, analog_switch_en_out;
    logic [5:0] pulse_channel_output_enable_in = 6'h00, pulse_channel_in = 6'h00;
    logic buzzer_enable_in = 1'b0, buzzer_output_in = 1'b0, converter_power_on_in = 1'b0;
    logic pin4_high_drive_out, pin5_high_drive_out, infrared_controller_out;
    logic [31:0] d;
    logic [1:0] r;
    int mismatches = 0;
    int checked = 0;

    always #10 clk_in = ~clk_in;

    gio_port dut_u (.clk_in, .rst_in, .awaddr_in, .awvalid_in, .awready_out, .wdata_in,
        .wstrb_in, .wvalid_in, .wready_out, .bresp_out, .bvalid_out, .bready_in, .araddr_in,
        .arvalid_in, .arready_out, .rdata_out, .rresp_out, .rvalid_out, .rready_in,
        .pa_pin_in, .pa_pin_out, .pa_pin_oe_out, .pb_pin_in, .pb_pin_out, .pb_pin_oe_out,
        .pulse_channel_output_enable_in, .pulse_channel_in, .buzzer_enable_in,
        .buzzer_output_in, .converter_power_on_in, .analog_channel_select_in,
        .pin4_high_drive_out, .pin5_high_drive_out, .analog_switch_en_out,
        .infrared_controller_out, .pa_level_out, .pb_level_out);

    gio_pin_model board_u (.pa_pin_out, .pa_pin_oe_out, .pb_pin_out, .pb_pin_oe_out,
        .pa_ext_in(pa_ext), .pa_ext_en_in(pa_ext_en), .pb_ext_in(pb_ext),
        .pa_level_out(pa_pin_in), .pb_level_out(pb_pin_in));

    // --------------------------------------------------------
    // reporting
    // --------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic hang(input int n);
        if (n >= 50) begin
            mismatches++;
            wrap_up();
        end
    endtask : hang

    // --------------------------------------------------------
    // bus master
    // --------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        int n;
        logic aw;
        logic w;
        n = 0;
        aw = 1'b0;
        w = 1'b0;
        awaddr_in <= a;
        wdata_in <= v;
        awvalid_in <= 1'b1;
        wvalid_in <= 1'b1;
        while (!(aw && w) && n < 50) begin
            @(posedge clk_in);
            n++;
            if (!aw && awready_out) begin
                aw = 1'b1;
                awvalid_in <= 1'b0;
            end
            if (!w && wready_out) begin
                w = 1'b1;
                wvalid_in <= 1'b0;
            end
        end
        do begin
            @(posedge clk_in);
            n++;
        end while (bvalid_out !== 1'b1 && n < 50);
        rs = bresp_out;
        hang(n);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        araddr_in <= a;
        arvalid_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (arready_out !== 1'b1 && n < 50);
        arvalid_in <= 1'b0;
        do begin
            @(posedge clk_in);
            n++;
        end while (rvalid_out !== 1'b1 && n < 50);
        v = rdata_out;
        rs = rresp_out;
        hang(n);
    endtask : rd

    task automatic wc(input logic [7:0] a, input logic [31:0] v);
        logic [1:0] rs;
        wr(a, v, rs);
        check(32'(rs), 32'(RESP_OKAY));
    endtask : wc

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        logic [1:0] rs;
        rd(a, v, rs);
        check(v, exp);
        check(32'(rs), 32'(RESP_OKAY));
    endtask : rc

    task automatic settle();
        repeat (4) @(posedge clk_in);
    endtask : settle

    // --------------------------------------------------------
    // tests
    // --------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        // pull-up levels need two synchroniser edges before a read can see them
        settle();
        rc(ADDR_PA_DATA, 32'h0000_00ff);
        rc(ADDR_PA_DIR, 32'h0);
        rc(ADDR_PB_DIR, 32'h0);
        rc(ADDR_DRIVE_SEL, 32'h0);
        check(32'(pa_pin_oe_out), 32'h0);
        $display("test reset done");
        // lower nibble driven by the board, upper nibble left to the pull-up
        pa_ext <= 8'h3c;
        pa_ext_en <= 8'h0f;
        wc(ADDR_PA_DATA, 32'h5a);
        settle();
        rc(ADDR_PA_DATA, 32'hfc);
        wc(ADDR_PA_DIR, 32'hff);
        settle();
        rc(ADDR_PA_DATA, 32'h5a);
        check(32'(pa_pin_out), 32'h5a);
        wc(ADDR_PA_DIR, 32'hf0);
        settle();
        rc(ADDR_PA_DIR, 32'hf0);
        rc(ADDR_PA_DATA, 32'h5c);
        check(32'(pa_pin_oe_out), 32'hf0);
        pa_ext <= 8'h03;
        @(posedge clk_in);
        #1 check(32'(pa_level_out[3:0]), 32'hc);
        @(posedge clk_in);
        #1 check(32'(pa_level_out[3:0]), 32'h3);
        $display("test port a done");
        wc(ADDR_PB_DIR, 32'hff);
        wc(ADDR_PB_DATA, 32'hff);
        settle();
        rc(ADDR_PB_DIR, 32'h0f);
        rc(ADDR_PB_DATA, 32'h0f);
        check(32'(pb_pin_oe_out), 32'hf);
        check(32'(pb_pin_out), 32'hf);
        wc(ADDR_PB_DIR, 32'h00);
        $display("test port b done");
        wc(ADDR_DRIVE_SEL, 32'hfe);
        settle();
        rc(ADDR_DRIVE_SEL, 32'h06);
        check(32'({pin5_high_drive_out, pin4_high_drive_out}), 32'h3);
        wc(ADDR_PA_DIR, 32'h00);
        pulse_channel_output_enable_in <= 6'h10;
        settle();
        check(32'({pin5_high_drive_out, pin4_high_drive_out}), 32'h1);
        $display("test drive done");
        pulse_channel_output_enable_in <= 6'h3f;
        pulse_channel_in <= 6'h2a;
        settle();
        check(32'(pa_pin_oe_out[5:0]), 32'h3f);
        check(32'(pa_pin_out[5:0]), 32'h2a);
        rc(ADDR_PA_DATA, 32'hea);
        buzzer_enable_in <= 1'b1;
        buzzer_output_in <= 1'b1;
        pulse_channel_in <= 6'h0a;
        settle();
        check(32'(pa_pin_out[5]), 32'h1);
        buzzer_output_in <= 1'b0;
        pulse_channel_in <= 6'h2a;
        settle();
        check(32'(pa_pin_out[5]), 32'h0);
        $display("test alternate done");
        pb_ext <= 4'h8;
        converter_power_on_in <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            analog_channel_select_in <= 2'(c);
            settle();
            check(32'(analog_switch_en_out), 32'(1 << c));
            check(32'(infrared_controller_out), (c == 3) ? 32'h0 : 32'h1);
        end
        check(32'(pb_level_out), 32'h8);
        converter_power_on_in <= 1'b0;
        settle();
        check(32'(analog_switch_en_out), 32'h0);
        $display("test analog done");
        rd(8'h40, d, r);
        check(32'(r), 32'(RESP_SLVERR));
        check(d, 32'h0);
        wr(8'h40, 32'h0, r);
        check(32'(r), 32'(RESP_SLVERR));
        $display("test unmapped done");
        wrap_up();
    end
endmodule : testbench

`default_nettype wire
